/* ssu_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "ssu_defines.vh"
module ssu_core #(
  parameter PAIRS = 2, // Number of push/pull bus pairs (1 or 2)
  parameter DEPTH = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Command bus
  input wire cmd_valid_i,
  input wire cmd_hash_i,
  input wire [3:0] cmd_op_i,
  input wire [11:0] cmd_addr_i,
  input wire [4:0] cmd_len_i,
  input wire cmd_ret_i,
  input wire cmd_pair_i,
  input wire [7:0] cmd_id_i,
  input wire [31:0] cmd_data_i,
  output reg cmd_full_o,
  // Push arbiter requests, one per pair
  output reg [1:0] push_req_o,
  input wire [1:0] push_gnt_i,
  output reg [31:0] push_data_o,
  output reg [7:0] push_destination_id_o,
  output reg push_last_o,
  // Pull arbiter requests, one per pair
  output reg [1:0] pull_req_o,
  input wire [1:0] pull_gnt_i,
  output reg [7:0] pull_id_o,
  input wire [1:0] pull_valid_i,
  input wire [63:0] pull_data_i,
  // Register bus
  output reg reg_req_o,
  output reg reg_wr_o,
  output reg [11:0] reg_addr_o,
  output reg [31:0] reg_wdata_o,
  input wire reg_ack_i,
  input wire [31:0] reg_rdata_i,
  // Peripheral bus
  output reg per_sel_o,
  output reg per_en_o,
  output reg per_write_o,
  output reg [11:0] per_addr_o,
  output reg [31:0] per_wdata_o,
  input wire per_rdy_i,
  input wire [31:0] per_rdata_i
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 8'h01;
  localparam S_READ = 8'h02;
  localparam S_WRITE = 8'h04;
  localparam S_RMW = 8'h08;
  localparam S_MOD = 8'h10;
  localparam S_REG = 8'h20;
  localparam S_PER = 8'h40;
  localparam S_REFLECT = 8'h80; // reflector_state
  // ----------------------------------------
  // Command inlet FIFO
  // ----------------------------------------
  wire mine = cmd_valid_i && !cmd_hash_i;
  wire [`SSU_CMD_W-1:0] cmd_pack;
  wire fifo_in_ready;
  wire fifo_out_valid;
  reg fifo_pop;
  wire [`SSU_CMD_W-1:0] head;
  // Reflector remap: one state, both ways
  assign cmd_pack = {cmd_op_i, cmd_addr_i, cmd_len_i, cmd_ret_i,
                     (cmd_op_i == `SSU_OP_REFLECT) ? 1'b0 : cmd_pair_i, cmd_id_i, cmd_data_i, 3'h0};
  ssu_fifo #(.WIDTH(`SSU_CMD_W), .DEPTH(DEPTH), .AW(5)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(mine),
    .in_ready_o(fifo_in_ready),
    .in_data_i(cmd_pack),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(head)
  );
  wire [3:0] h_op = head[65:62];
  wire [11:0] h_addr = head[61:50];
  wire [4:0] h_len = head[49:45];
  wire h_ret = head[44];
  wire h_pair = head[43];
  wire [7:0] h_id = head[42:35];
  wire [31:0] h_data = head[34:3];
  // ----------------------------------------
  // Memory and rings
  // ----------------------------------------
  reg [31:0] mem [0:`SSU_MEM_WORDS-1];
  reg [11:0] ring_base [0:`SSU_RING_COUNT-1];
  reg [1:0] ring_size [0:`SSU_RING_COUNT-1];
  reg [10:0] ring_head [0:`SSU_RING_COUNT-1];
  reg [10:0] ring_tail [0:`SSU_RING_COUNT-1];
  reg [7:0] state_reg;
  reg [11:0] addr_reg; // Current word address
  reg [4:0] left_reg; // Words still to move
  reg [3:0] op_reg;
  reg ret_reg;
  reg pair_reg;
  reg [7:0] id_reg;
  reg [31:0] opnd_reg; // Atomic operand
  reg [31:0] old_reg; // Pre-modified value
  reg [3:0] ring_reg;
  reg is_ring_reg;
  reg need_pull_reg;
  wire pull_v = pull_valid_i[pair_reg];
  wire [31:0] pull_d = pair_reg ? pull_data_i[63:32] : pull_data_i[31:0];
  wire push_g = push_gnt_i[pair_reg];
  // Ring occupancy and mask for the head command
  wire [3:0] hr = h_addr[3:0];
  wire [10:0] h_mask = (11'h80 << ring_size[hr]) - 11'h1;
  wire [10:0] h_count = (ring_tail[hr] - ring_head[hr]) & h_mask;
  wire [10:0] r_mask = (11'h80 << ring_size[ring_reg]) - 11'h1;
  // Ring slot address
  wire [11:0] rd_slot = ring_base[ring_reg] | {1'b0, ring_head[ring_reg] & r_mask};
  wire [11:0] wr_slot = ring_base[ring_reg] | {1'b0, ring_tail[ring_reg] & r_mask};
  // Atomic modify
  reg [31:0] mod_val;
  always @* begin
    mod_val = old_reg;
    case (op_reg)
      `SSU_OP_BSET: mod_val = old_reg | opnd_reg;
      `SSU_OP_BCLR: mod_val = old_reg & ~opnd_reg;
      `SSU_OP_INC: mod_val = old_reg + 32'h1;
      `SSU_OP_DEC: mod_val = old_reg - 32'h1;
      `SSU_OP_ADD: mod_val = old_reg + opnd_reg;
      `SSU_OP_SUB: mod_val = old_reg - opnd_reg;
      `SSU_OP_SWAP: mod_val = opnd_reg;
      default: mod_val = old_reg;
    endcase
  end
  // Whether an atomic needs a pulled operand
  wire h_atomic_pull = (h_op == `SSU_OP_BSET) || (h_op == `SSU_OP_BCLR) || (h_op == `SSU_OP_ADD) ||
                       (h_op == `SSU_OP_SUB) || (h_op == `SSU_OP_SWAP);
  // Length 0 is treated as 1 and longer is capped at 16
  wire [4:0] h_n = (h_len == 5'h0) ? 5'h1 : ((h_len > 5'h10) ? 5'h10 : h_len);
  // Pop the head only when idle
  always @* begin
    fifo_pop = (state_reg == S_IDLE) && fifo_out_valid;
  end
  integer i;
  // ----------------------------------------
  // Main controller
  // ----------------------------------------
  // Whole-word writes, no byte mask
  always @(posedge clk_i) begin
    if (ce_i && state_reg == S_WRITE && pull_v) begin
      mem[is_ring_reg ? wr_slot : addr_reg] <= pull_d;
    end
    if (ce_i && state_reg == S_MOD) begin
      mem[addr_reg] <= mod_val;
    end
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      addr_reg <= 12'h0;
      left_reg <= 5'h0;
      op_reg <= 4'h0;
      ret_reg <= 1'b0;
      pair_reg <= 1'b0;
      id_reg <= 8'h0;
      opnd_reg <= 32'h0;
      old_reg <= 32'h0;
      ring_reg <= 4'h0;
      is_ring_reg <= 1'b0;
      need_pull_reg <= 1'b0;
      cmd_full_o <= 1'b0;
      push_req_o <= 2'h0;
      push_data_o <= 32'h0;
      push_destination_id_o <= 8'h0;
      push_last_o <= 1'b0;
      pull_req_o <= 2'h0;
      pull_id_o <= 8'h0;
      reg_req_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_addr_o <= 12'h0;
      reg_wdata_o <= 32'h0;
      per_sel_o <= 1'b0;
      per_en_o <= 1'b0;
      per_write_o <= 1'b0;
      per_addr_o <= 12'h0;
      per_wdata_o <= 32'h0;
      for (i = 0; i < `SSU_RING_COUNT; i = i + 1) begin
        ring_base[i] <= 12'h0;
        ring_size[i] <= `SSU_RSZ_128;
        ring_head[i] <= 11'h0;
        ring_tail[i] <= 11'h0;
      end
    end else if (ce_i) begin
      cmd_full_o <= !fifo_in_ready || (mine && fifo_out_valid && !fifo_pop);
      // Granted requests drop
      if (push_g) begin
        push_req_o <= 2'h0;
        push_last_o <= 1'b0;
      end
      if (pull_gnt_i[pair_reg]) begin
        pull_req_o <= 2'h0;
      end
      case (state_reg)
        S_IDLE: begin
          if (fifo_out_valid) begin
            op_reg <= h_op;
            addr_reg <= h_addr;
            ret_reg <= h_ret;
            pair_reg <= (PAIRS > 1) ? h_pair : 1'b0;
            id_reg <= h_id;
            left_reg <= h_n;
            is_ring_reg <= 1'b0;
            ring_reg <= hr;
            case (h_op)
              `SSU_OP_READ: state_reg <= S_READ;
              `SSU_OP_WRITE: begin
                pull_req_o[(PAIRS > 1) ? h_pair : 1'b0] <= 1'b1;
                pull_id_o <= h_id;
                state_reg <= S_WRITE;
              end
              `SSU_OP_GET: begin
                is_ring_reg <= 1'b1;
                if (h_count >= {6'h0, h_n}) begin
                  state_reg <= S_READ;
                end else begin
                  // Ring holding fewer words than requested: one nil word
                  push_req_o[(PAIRS > 1) ? h_pair : 1'b0] <= 1'b1;
                  push_data_o <= 32'h0;
                  push_destination_id_o <= h_id;
                  push_last_o <= 1'b1;
                end
              end
              `SSU_OP_PUT: begin
                is_ring_reg <= 1'b1;
                pull_req_o[(PAIRS > 1) ? h_pair : 1'b0] <= 1'b1;
                pull_id_o <= h_id;
                state_reg <= S_WRITE;
              end
              `SSU_OP_RING_CFG: begin
                // Base [11:0], size [13:12]; pointers cleared
                ring_base[hr] <= h_data[11:0];
                ring_size[hr] <= h_data[13:12];
                ring_head[hr] <= 11'h0;
                ring_tail[hr] <= 11'h0;
              end
              `SSU_OP_REG_RD, `SSU_OP_REG_WR, `SSU_OP_REG_FWR: begin
                reg_addr_o <= h_addr;
                reg_wr_o <= (h_op != `SSU_OP_REG_RD);
                reg_wdata_o <= h_data;
                if (h_op == `SSU_OP_REG_WR) begin
                  pull_req_o[(PAIRS > 1) ? h_pair : 1'b0] <= 1'b1;
                  pull_id_o <= h_id;
                end else begin
                  reg_req_o <= 1'b1;
                end
                state_reg <= S_REG;
              end
              `SSU_OP_REFLECT: begin
                pull_req_o[0] <= 1'b1;
                pull_id_o <= h_id;
                state_reg <= S_REFLECT;
              end
              default: begin
                // Atomics
                opnd_reg <= h_data;
                need_pull_reg <= h_atomic_pull;
                if (h_atomic_pull) begin
                  pull_req_o[(PAIRS > 1) ? h_pair : 1'b0] <= 1'b1;
                  pull_id_o <= h_id;
                end
                state_reg <= S_RMW;
              end
            endcase
          end
        end
        S_READ: begin
          if (!(|push_req_o) || push_g) begin
            push_req_o[pair_reg] <= 1'b1;
            push_data_o <= mem[is_ring_reg ? rd_slot : addr_reg];
            push_destination_id_o <= id_reg;
            id_reg <= id_reg + 8'h1;
            push_last_o <= (left_reg == 5'h1);
            addr_reg <= addr_reg + 12'h1;
            if (is_ring_reg) begin
              ring_head[ring_reg] <= (ring_head[ring_reg] + 11'h1) & r_mask;
            end
            left_reg <= left_reg - 5'h1;
            if (left_reg == 5'h1) begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_WRITE: begin
          if (pull_v) begin
            addr_reg <= addr_reg + 12'h1;
            if (is_ring_reg) begin
              ring_tail[ring_reg] <= (ring_tail[ring_reg] + 11'h1) & r_mask;
            end
            left_reg <= left_reg - 5'h1;
            if (left_reg == 5'h1) begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_RMW: begin
          old_reg <= mem[addr_reg];
          if (ret_reg) begin
            push_req_o[pair_reg] <= 1'b1;
            push_data_o <= mem[addr_reg];
            push_destination_id_o <= id_reg | 8'h01;
            push_last_o <= 1'b1;
            ret_reg <= 1'b0;
          end
          if (!need_pull_reg) begin
            state_reg <= S_MOD;
          end else if (pull_v) begin
            opnd_reg <= pull_d;
            state_reg <= S_MOD;
          end
        end
        S_MOD: begin
          state_reg <= S_IDLE;
        end
        S_REG: begin
          if (!reg_req_o && pull_v) begin
            reg_wdata_o <= pull_d;
            reg_req_o <= 1'b1;
          end else if (reg_req_o && reg_ack_i) begin
            reg_req_o <= 1'b0;
            if (!reg_wr_o) begin
              push_req_o[pair_reg] <= 1'b1;
              push_data_o <= reg_rdata_i;
              push_destination_id_o <= id_reg;
              push_last_o <= 1'b1;
            end
            state_reg <= S_IDLE;
          end
        end
        S_PER: begin
          per_en_o <= 1'b1;
          if (per_en_o && (per_write_o || per_rdy_i)) begin
            per_sel_o <= 1'b0;
            per_en_o <= 1'b0;
            if (!per_write_o) begin
              push_req_o[pair_reg] <= 1'b1;
              push_data_o <= per_rdata_i;
              push_destination_id_o <= id_reg;
              push_last_o <= 1'b1;
            end
            state_reg <= S_IDLE;
          end
        end
        S_REFLECT: begin
          // Pulled word goes straight out on the push side of pair 0
          if (pull_valid_i[0]) begin
            push_req_o[0] <= 1'b1;
            push_data_o <= pull_data_i[31:0];
            push_destination_id_o <= id_reg;
            id_reg <= id_reg + 8'h1;
            push_last_o <= (left_reg == 5'h1);
            left_reg <= left_reg - 5'h1;
            if (left_reg == 5'h1) begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // ssu_core
`default_nettype wire

/* ssu_defines.vh */
`ifndef SSU_DEFINES_VH
`define SSU_DEFINES_VH
// Memory geometry
`define SSU_MEM_WORDS 4096
`define SSU_ADDR_W 12
`define SSU_MAX_LEN 16
`define SSU_RING_COUNT 16
// Command opcodes on cmd_op_i
`define SSU_OP_READ 4'h0
`define SSU_OP_WRITE 4'h1
`define SSU_OP_BSET 4'h2
`define SSU_OP_BCLR 4'h3
`define SSU_OP_INC 4'h4
`define SSU_OP_DEC 4'h5
`define SSU_OP_ADD 4'h6
`define SSU_OP_SUB 4'h7
`define SSU_OP_SWAP 4'h8
`define SSU_OP_GET 4'h9
`define SSU_OP_PUT 4'ha
`define SSU_OP_RING_CFG 4'hb
`define SSU_OP_REG_RD 4'hc
`define SSU_OP_REG_WR 4'hd
`define SSU_OP_REG_FWR 4'he
`define SSU_OP_REFLECT 4'hf
// Command FIFO
`define SSU_FIFO_DEPTH 32
`define SSU_CMD_W 66
// Ring size codes
`define SSU_RSZ_128 2'h0
`define SSU_RSZ_1024 2'h3
`endif

/* ssu_fifo.v */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Synchronous FIFO with valid/ready on both sides
// ----------------------------------------
module ssu_fifo #(
  parameter WIDTH = 66,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
  reg [AW:0] wr_ptr_reg; // Write pointer with wrap bit
  reg [AW:0] rd_ptr_reg; // Read pointer with wrap bit
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire do_wr = ce_i && in_valid_i && !full;
  wire do_rd = ce_i && out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];
  // Data store, no reset needed
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
  // Pointer update
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // ssu_fifo
`default_nettype wire

/* ssu_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssu_defines.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module ssu_core_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command side
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_hash_i,
  input wire logic [3:0] cmd_op_i,
  input wire logic cmd_full_o,
  // Push and pull side
  input wire logic [1:0] push_req_o,
  input wire logic [1:0] push_gnt_i,
  input wire logic [31:0] push_data_o,
  input wire logic [7:0] push_destination_id_o,
  input wire logic push_last_o,
  input wire logic [1:0] pull_req_o,
  input wire logic [1:0] pull_gnt_i,
  input wire logic [7:0] pull_id_o,
  // Register and peripheral side
  input wire logic reg_req_o,
  input wire logic reg_wr_o,
  input wire logic [11:0] reg_addr_o,
  input wire logic reg_ack_i,
  input wire logic per_en_o,
  input wire logic [11:0] per_addr_o,
  input wire logic per_rdy_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Nothing outstanding
  wire logic quiet = (push_req_o == 2'h0) && (pull_req_o == 2'h0) && !reg_req_o;
  // Command taken
  wire logic take = ce_i && cmd_valid_i && !cmd_hash_i && !cmd_full_o;

  property p_push_hold;
    push_req_o[0] && !push_gnt_i[0] |=> push_req_o[0] && $stable(push_data_o) && $stable(push_destination_id_o);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("push beat changed");

  property p_id_step;
    push_req_o[0] && push_gnt_i[0] && !push_last_o |=> push_req_o[0] && push_destination_id_o == $past(push_destination_id_o) + 8'h01;
  endproperty
  a_id_step: assert property (p_id_step) else $error("push_destination_id did not step by one");

  property p_pull_hold;
    pull_req_o[0] && !pull_gnt_i[0] |=> pull_req_o[0] && $stable(pull_id_o);
  endproperty
  a_pull_hold: assert property (p_pull_hold) else $error("pull request dropped");

  property p_reg_hold;
    reg_req_o && !reg_ack_i |=> reg_req_o && $stable(reg_addr_o) && $stable(reg_wr_o);
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("register request changed");

  property p_fast_nopull;
    take && cmd_op_i == `SSU_OP_REG_FWR && quiet |=> (pull_req_o == 2'h0) [*6];
  endproperty
  a_fast_nopull: assert property (p_fast_nopull) else $error("fast write issued a pull");

  property p_fast_reg;
    take && cmd_op_i == `SSU_OP_REG_FWR |-> ##[1:8] (reg_req_o && reg_wr_o);
  endproperty
  a_fast_reg: assert property (p_fast_reg) else $error("fast write never reached register bus");

  property p_hash_quiet;
    ce_i && cmd_valid_i && cmd_hash_i && quiet |=> quiet [*4];
  endproperty
  a_hash_quiet: assert property (p_hash_quiet) else $error("hash command was served");

  property p_per_hold;
    per_en_o && !per_rdy_i |=> per_en_o && $stable(per_addr_o);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("peripheral read closed early");

  property p_reset_quiet;
    $fell(rst_i) |-> quiet && !cmd_full_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not idle after reset");
endmodule // ssu_core_checker

bind ssu_core ssu_core_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
  .cmd_hash_i(cmd_hash_i), .cmd_op_i(cmd_op_i), .cmd_full_o(cmd_full_o), .push_req_o(push_req_o),
  .push_gnt_i(push_gnt_i), .push_data_o(push_data_o), .push_destination_id_o(push_destination_id_o),
  .push_last_o(push_last_o), .pull_req_o(pull_req_o), .pull_gnt_i(pull_gnt_i), .pull_id_o(pull_id_o),
  .reg_req_o(reg_req_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_ack_i(reg_ack_i),
  .per_en_o(per_en_o), .per_addr_o(per_addr_o), .per_rdy_i(per_rdy_i));
`default_nettype wire

/* ssu_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Arbiters, pull sources and register slave
// ----------------------------------------
module ssu_far_model #(
  parameter logic [31:0] RD_VALUE = 32'h5eed_0000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic hold_i,
  input wire logic [4:0] pull_cnt_i,
  input wire logic [31:0] pull_base_i,
  // Unit requests
  input wire logic [1:0] push_req_i,
  input wire logic [1:0] pull_req_i,
  input wire logic reg_req_i,
  // Answers
  output logic [1:0] push_gnt_o,
  output logic [1:0] pull_gnt_o,
  output logic [1:0] pull_valid_o,
  output logic [63:0] pull_data_o,
  output logic reg_ack_o,
  output logic [31:0] reg_rdata_o
);
  logic [4:0] left; // Pull words still to send
  logic [4:0] idx; // Index of next pull word
  logic pair; // Pair that won the pull
  // Prompt grants; hold stalls them
  assign push_gnt_o = push_req_i & {2{~hold_i}};
  assign pull_gnt_o = pull_req_i & {2{~hold_i}};
  // Data valid only with ack
  assign reg_rdata_o = reg_ack_o ? RD_VALUE : ~RD_VALUE;
  // Pull source: one pulse per word
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left <= 5'h00;
      idx <= 5'h00;
      pair <= 1'b0;
      pull_valid_o <= 2'h0;
      pull_data_o <= 64'h0;
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_req_i & ~reg_ack_o;
      pull_valid_o <= 2'h0;
      pull_data_o <= ~pull_data_o;
      if (|(pull_req_i & pull_gnt_o)) begin
        left <= pull_cnt_i;
        idx <= 5'h00;
        pair <= pull_req_i[1];
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
        idx <= idx + 5'h01;
        pull_valid_o[pair] <= 1'b1;
        pull_data_o <= {2{pull_base_i + {27'h0, idx}}};
      end
    end
  end
endmodule // ssu_far_model
`default_nettype wire

/* shared_scratchpad_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssu_defines.vh"
module shared_scratchpad_unit_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam logic [31:0] RDV = 32'h5eed_0000; // Model read value
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, hold = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_hash_i = 1'b0, cmd_ret_i = 1'b0, cmd_pair_i = 1'b0;
  logic [3:0] cmd_op_i = 4'h0;
  logic [11:0] cmd_addr_i = 12'h000;
  logic [4:0] cmd_len_i = 5'h01, pcnt = 5'h01;
  logic [7:0] cmd_id_i = 8'h00;
  logic [31:0] cmd_data_i = 32'h0, pbase = 32'h0;
  wire logic cmd_full_o, push_last_o, reg_req_o, reg_wr_o, reg_ack_i;
  wire logic [1:0] push_req_o, push_gnt_i, pull_req_o, pull_gnt_i, pull_valid_i;
  wire logic [31:0] push_data_o, reg_wdata_o, reg_rdata_i;
  wire logic [7:0] push_destination_id_o;
  wire logic [63:0] pull_data_i;
  wire logic [11:0] reg_addr_o;
  int fails = 0, samples_checked = 0;
  // Clock of 10 ns
  always #5 clk_i = ~clk_i;
  ssu_core #(.PAIRS(2), .DEPTH(32)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_hash_i(cmd_hash_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_len_i(cmd_len_i), .cmd_ret_i(cmd_ret_i), .cmd_pair_i(cmd_pair_i), .cmd_id_i(cmd_id_i),
    .cmd_data_i(cmd_data_i), .cmd_full_o(cmd_full_o), .push_req_o(push_req_o), .push_gnt_i(push_gnt_i),
    .push_data_o(push_data_o), .push_destination_id_o(push_destination_id_o), .push_last_o(push_last_o),
    .pull_req_o(pull_req_o), .pull_gnt_i(pull_gnt_i), .pull_id_o(), .pull_valid_i(pull_valid_i),
    .pull_data_i(pull_data_i), .reg_req_o(reg_req_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .reg_ack_i(reg_ack_i), .reg_rdata_i(reg_rdata_i), .per_sel_o(),
    .per_en_o(), .per_write_o(), .per_addr_o(), .per_wdata_o(), .per_rdy_i(1'b1),
    .per_rdata_i(32'h0));
  ssu_far_model #(.RD_VALUE(RDV)) u_far (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .pull_cnt_i(pcnt),
    .pull_base_i(pbase), .push_req_i(push_req_o), .pull_req_i(pull_req_o), .reg_req_i(reg_req_o),
    .push_gnt_o(push_gnt_i), .pull_gnt_o(pull_gnt_i), .pull_valid_o(pull_valid_i),
    .pull_data_o(pull_data_i), .reg_ack_o(reg_ack_i), .reg_rdata_o(reg_rdata_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // One command
  task automatic go(input logic [3:0] op, input logic [11:0] a, input logic [4:0] n, input logic [7:0] id,
                    input logic [31:0] d);
    @(posedge clk_i);
    #1;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_len_i = n;
    cmd_id_i = id;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
  endtask
  // Collect n push beats on pair p
  task automatic pop(input int n, input logic [31:0] d0, input logic [7:0] id0, input int p);
    int k;
    int t;
    k = 0;
    for (t = 0; t < 300 && k < n; t++) begin
      @(negedge clk_i);
      if (push_req_o[p] === 1'b1 && push_gnt_i[p] === 1'b1) begin
        chk("push data", d0 + k, push_data_o);
        chk("push_destination_id", id0 + k, push_destination_id_o);
        chk("push last", k == n - 1, push_last_o);
        k++;
      end
    end
    chk("push beats", n, k);
  endtask
  // Wait for pull words
  task automatic pull_wait;
    int t;
    for (t = 0; t < 100 && pull_valid_i === 2'h0; t++) @(negedge clk_i);
    for (; t < 200 && pull_valid_i !== 2'h0; t++) @(negedge clk_i);
  endtask
  // Check register request
  task automatic reg_wait(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    for (t = 0; t < 50 && reg_req_o !== 1'b1; t++) @(negedge clk_i);
    chk("reg write", wr, reg_wr_o);
    chk("reg addr", a, reg_addr_o);
    if (wr) chk("reg data", d, reg_wdata_o);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // 16-word write and read back
  task automatic t_rw(input logic p, input logic [11:0] a);
    pcnt = 5'h10;
    pbase = 32'h1234_5600;
    cmd_pair_i = p;
    go(`SSU_OP_WRITE, a, 5'h10, 8'h20, 32'h0);
    go(`SSU_OP_READ, a, 5'h10, 8'h40, 32'h0);
    cmd_pair_i = 1'b0;
    pop(16, pbase, 8'h40, p);
    $display("done rw");
  endtask
  // Every atomic kind
  task automatic t_atomic;
    logic [3:0] ops [7] = '{`SSU_OP_BSET, `SSU_OP_BCLR, `SSU_OP_INC, `SSU_OP_DEC, `SSU_OP_ADD,
                            `SSU_OP_SUB, `SSU_OP_SWAP};
    logic [31:0] res [7] = '{32'hf1, 32'he0, 32'hf1, 32'hef, 32'h101, 32'hdf, 32'h11};
    for (int i = 0; i < 7; i++) begin
      pcnt = 5'h01;
      pbase = 32'hf0;
      go(`SSU_OP_WRITE, 12'h100, 5'h01, 8'h30, 32'h0);
      pull_wait();
      pbase = 32'h11;
      cmd_ret_i = 1'b1;
      go(ops[i], 12'h100, 5'h01, 8'h30, 32'h0);
      cmd_ret_i = 1'b0;
      pop(1, 32'hf0, 8'h31, 0);
      go(`SSU_OP_READ, 12'h100, 5'h01, 8'h40, 32'h0);
      pop(1, res[i], 8'h40, 0);
    end
    $display("done atomic");
  endtask
  // Register bus commands
  task automatic t_reg;
    go(`SSU_OP_REG_FWR, 12'h0a5, 5'h01, 8'h60, 32'hcafe_0001);
    reg_wait(1'b1, 12'h0a5, 32'hcafe_0001);
    pcnt = 5'h01;
    pbase = 32'h0bad_0002;
    go(`SSU_OP_REG_WR, 12'h0c7, 5'h01, 8'h62, 32'h0);
    reg_wait(1'b1, 12'h0c7, pbase);
    go(`SSU_OP_REG_RD, 12'h0b6, 5'h01, 8'h61, 32'h0);
    reg_wait(1'b0, 12'h0b6, 32'h0);
    pop(1, RDV, 8'h61, 0);
    $display("done reg");
  endtask
  // Reflector on pair 0 only
  task automatic t_refl;
    pcnt = 5'h03;
    pbase = 32'h7e7e_0000;
    cmd_pair_i = 1'b1;
    go(`SSU_OP_REFLECT, 12'h000, 5'h03, 8'h50, 32'h0);
    cmd_pair_i = 1'b0;
    pop(3, pbase, 8'h50, 0);
    $display("done reflect");
  endtask
  // 128-word ring: put, get
  task automatic t_ring;
    go(`SSU_OP_RING_CFG, 12'h005, 5'h01, 8'h00, {18'h0, `SSU_RSZ_128, 12'h200});
    pcnt = 5'h02;
    pbase = 32'h0f0f_0000;
    go(`SSU_OP_PUT, 12'h005, 5'h02, 8'h70, 32'h0);
    go(`SSU_OP_GET, 12'h005, 5'h02, 8'h78, 32'h0);
    pop(2, pbase, 8'h78, 0);
    $display("done ring");
  endtask
  // Hash command ignored
  task automatic t_hash;
    cmd_hash_i = 1'b1;
    go(`SSU_OP_READ, 12'h000, 5'h01, 8'h90, 32'h0);
    cmd_hash_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk("hash push", 2'h0, push_req_o);
    $display("done hash");
  endtask
  // Reads against a stalled push bus
  task automatic t_full;
    logic seen;
    int k;
    seen = 1'b0;
    k = 0;
    hold = 1'b1;
    @(posedge clk_i);
    #1;
    cmd_op_i = `SSU_OP_READ;
    cmd_len_i = 5'h01;
    cmd_valid_i = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      if (cmd_full_o === 1'b1) seen = 1'b1;
    end
    cmd_valid_i = 1'b0;
    hold = 1'b0;
    chk("full flag", 1'b1, seen);
    repeat (300) begin
      @(negedge clk_i);
      if (push_req_o[0] === 1'b1 && push_gnt_i[0] === 1'b1) k++;
    end
    chk("accepted", 1'b1, k >= 32 && k <= 40);
    chk("full after drain", 1'b0, cmd_full_o);
    $display("done full");
  endtask
  // ----------------------------------------
  // Closing and main sequence
  // ----------------------------------------
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_rw(1'b0, 12'hff0);
    t_rw(1'b1, 12'h000);
    t_atomic();
    t_reg();
    t_refl();
    t_ring();
    t_hash();
    t_full();
    wrap_up();
  end
endmodule // shared_scratchpad_unit_bench
`default_nettype wire
